// ==== hw/pmdt_clk_div.sv ====
// CPU state tick generator for high-speed, medium-speed and subactive clocks
`timescale 1ns/1ns
module pmdt_clk_div (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  // Selection
  input  wire pmdt_pkg::pmdt_clk_e i_clk_sel,
  input  wire logic [1:0]        i_sub_div_sel,
  input  wire logic              i_watch_tick,
  // Tick out
  output logic                   o_tick
);
  import pmdt_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] lim;
  logic       adv;

  // Terminal count per clock choice
  always_comb begin
    lim = HS_LIM;
    adv = 1'b1;
    unique case (i_clk_sel)
      CLK_HS: lim = HS_LIM;
      CLK_MS: lim = MS_LIM;
      CLK_SUB: begin
        adv = i_watch_tick;
        if (i_sub_div_sel == SUB_SEL_D8) begin
          lim = SUB_LIM_D8;
        end else if (i_sub_div_sel == SUB_SEL_D4) begin
          lim = SUB_LIM_D4;
        end else begin
          lim = SUB_LIM_D2;
        end
      end
      default: lim = HS_LIM;
    endcase
  end

  // Divider counter; compare with >= so a select change never stalls it
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 4'h0;
      o_tick  <= 1'b0;
    end else if (adv) begin
      if (cnt_reg >= lim) begin
        cnt_reg <= 4'h0;
        o_tick  <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
        o_tick  <= 1'b0;
      end
    end else begin
      o_tick <= 1'b0;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // A switch away from medium speed right after its tick may legally tick sooner
  ms_gap_a: assert property ((i_clk_sel == CLK_MS && o_tick && $stable(i_clk_sel)) |=>
    (!o_tick || i_clk_sel != CLK_MS) [*8])
    else $error("medium-speed tick came too soon");
  hs_rate_a: assert property ((i_clk_sel == CLK_HS && o_tick) ##1 (i_clk_sel == CLK_HS) [*2] |->
    !$past(o_tick) && o_tick)
    else $error("high-speed tick not every second cycle");

endmodule

// ==== hw/pmdt_ctrl.sv ====
// Power-mode controller with sleep, standby, watch and direct-transfer sequencing
`timescale 1ns/1ns
// Summary of operation
// - Standby wake, or watch wake with low speed clear, goes medium-speed when selected
// - Any interrupt wakes sleep into high or medium speed, whichever is selected
// - Masked or disabled interrupts never wake
// - SLEEP with standby, no low, no timer: standby
// - SLEEP with standby and timer bit: watch
// - SLEEP with neither standby nor low: sleep
// - Reset pin low forces reset state
// - Medium-speed CPU clock is high-speed over eight
// - Direct transfer switches mode, raises its interrupt
// - Disabled direct interrupt falls back to sleep/watch
// - Masked direct transfer ends in unclearable sleep/watch
// - High to medium speed via sleep
// - Medium to high speed via sleep
// - Active to subactive via watch
// - Subactive to high speed after settling wait
// - Subactive to medium speed after settling wait
// - Latency: three old states, fourteen new
// - Settling wait in new-mode states before exception
// - Subactive clock is watch clock over 2/4/8
module pmdt_ctrl #(
  parameter int SETTLE_BASE = 8192  // Shortest settling wait, in states
) (
  // Clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst_b,
  input  wire logic                i_reset_pin_n,
  input  wire logic                i_watch_tick,
  // CPU events and mask
  input  wire logic                i_sleep_exec,
  input  wire logic                i_cond_code_int_mask,
  // Mode select bits
  input  wire logic                i_software_standby_select,
  input  wire logic                i_low_speed_select,
  input  wire logic                i_medium_speed_select,
  input  wire logic                i_direct_transfer_on,
  input  wire logic                i_timer_a_watch_select,
  input  wire logic [2:0]          i_settle_wait_sel,
  input  wire logic [1:0]          i_sub_div_sel,
  // Interrupt requests
  input  wire logic                i_ext_int_zero,
  input  wire logic                i_ext_int_one,
  input  wire logic [7:0]          i_wake_pin,
  input  wire logic                i_timer_a_int,
  input  wire logic                i_other_int,
  // Interrupt enables
  input  wire logic                i_ext_int_zero_en,
  input  wire logic                i_ext_int_one_en,
  input  wire logic [7:0]          i_wake_pin_en,
  input  wire logic                i_timer_a_int_en,
  input  wire logic                i_other_int_en,
  input  wire logic                i_dt_int_en,
  // Status and control out
  output pmdt_pkg::pmdt_mode_e     o_mode,
  output pmdt_pkg::pmdt_clk_e      o_run_clk,
  output logic                     o_cpu_ce,
  output logic                     o_cpu_reset,
  output logic                     o_main_osc_on,
  output logic                     o_exc_start,
  output logic                     o_dt_int
);
  import pmdt_pkg::*;

  localparam logic [17:0] SETTLE_BASE_W = 18'(SETTLE_BASE);

  pmdt_mode_e  mode_reg;
  pmdt_mode_e  mode_next;
  pmdt_mode_e  slp_mode;
  pmdt_clk_e   run_clk_reg;
  pmdt_clk_e   clk_next;
  pmdt_clk_e   tgt_clk_reg;
  pmdt_clk_e   tgt_next;
  pmdt_clk_e   slp_tgt;
  pmdt_clk_e   act_clk;
  pmdt_clk_e   tick_sel;
  logic        via_reg;
  logic        via_next;
  logic        slp_via;
  logic        dt_reg;
  logic        dt_next;
  logic [17:0] cnt_reg;
  logic [17:0] load_val;
  logic [17:0] settle_cnt;
  logic [2:0]  sts_shift;
  logic        load;
  logic        exc_go;
  logic        tick;
  logic        done;
  logic        act_s;
  logic        dt_ok;
  logic        irq_common;
  logic        wake_stby;
  logic        wake_watch;
  logic        wake_any;
  logic        cpu_run;

  // Wake qualification by mask and enables
  assign irq_common = (i_ext_int_zero & i_ext_int_zero_en) | (|(i_wake_pin & i_wake_pin_en));
  assign wake_stby  = !i_cond_code_int_mask & (irq_common | (i_ext_int_one & i_ext_int_one_en));
  assign wake_watch = !i_cond_code_int_mask & (irq_common | (i_timer_a_int & i_timer_a_int_en));
  assign wake_any   = wake_stby | wake_watch | (!i_cond_code_int_mask & i_other_int & i_other_int_en);

  // Mode and timing helpers
  assign act_s   = (mode_reg == M_HS) || (mode_reg == M_MS) || (mode_reg == M_SUB);
  assign dt_ok   = i_direct_transfer_on & i_dt_int_en & !i_cond_code_int_mask;
  assign act_clk = i_medium_speed_select ? CLK_MS : CLK_HS;
  assign tick_sel  = (mode_reg == M_SETTLE) ? tgt_clk_reg : run_clk_reg;
  assign sts_shift = i_settle_wait_sel[2] ? STS_MAX_SHIFT : {1'b0, i_settle_wait_sel[1:0]};
  assign settle_cnt = SETTLE_BASE_W << sts_shift;
  assign done = tick && (cnt_reg == 18'h00001);

  // State tick source
  pmdt_clk_div u_div (
    .i_sys_clk     (i_sys_clk),
    .i_rst_b       (i_rst_b),
    .i_clk_sel     (tick_sel),
    .i_sub_div_sel (i_sub_div_sel),
    .i_watch_tick  (i_watch_tick),
    .o_tick        (tick)
  );

  // SLEEP decision from bits sampled at execution
  always_comb begin
    slp_mode = M_SLEEP;
    slp_tgt  = run_clk_reg;
    slp_via  = 1'b0;
    if (run_clk_reg == CLK_SUB) begin
      if (i_software_standby_select && i_timer_a_watch_select && dt_ok && !i_low_speed_select) begin
        slp_mode = M_DTOLD;
        slp_tgt  = act_clk;
        slp_via  = 1'b1;
      end else if (i_software_standby_select) begin
        slp_mode = M_WATCH;
      end else begin
        slp_mode = M_SSLEEP;
      end
    end else if (i_software_standby_select && i_timer_a_watch_select) begin
      if (dt_ok && i_low_speed_select) begin
        slp_mode = M_DTOLD;
        slp_tgt  = CLK_SUB;
        slp_via  = 1'b1;
      end else begin
        slp_mode = M_WATCH;
      end
    end else if (i_software_standby_select) begin
      slp_mode = M_STBY;
    end else if (dt_ok && !i_low_speed_select && (i_medium_speed_select != (run_clk_reg == CLK_MS))) begin
      slp_mode = M_DTOLD;
      slp_tgt  = act_clk;
    end else begin
      slp_mode = M_SLEEP;
    end
  end

  // Next mode, clock and counter load
  always_comb begin
    mode_next = mode_reg;
    clk_next  = run_clk_reg;
    tgt_next  = tgt_clk_reg;
    via_next  = via_reg;
    dt_next   = dt_reg;
    load      = 1'b0;
    load_val  = EXC_CNT;
    exc_go    = 1'b0;
    unique case (mode_reg)
      M_RESET: begin
        mode_next = M_HS;
        clk_next  = CLK_HS;
      end
      M_HS, M_MS, M_SUB: begin
        if (i_sleep_exec) begin
          mode_next = slp_mode;
          tgt_next  = slp_tgt;
          via_next  = slp_via;
          dt_next   = (slp_mode == M_DTOLD);
          load      = 1'b1;
          load_val  = DT_OLD_CNT;
        end
      end
      M_SLEEP: begin
        if (wake_any) begin
          mode_next = M_EXC;
          clk_next  = act_clk;
          load      = 1'b1;
          exc_go    = 1'b1;
        end
      end
      M_STBY: begin
        if (wake_stby) begin
          mode_next = M_SETTLE;
          tgt_next  = act_clk;
          load      = 1'b1;
          load_val  = settle_cnt;
        end
      end
      M_WATCH: begin
        if (wake_watch && i_low_speed_select) begin
          mode_next = M_EXC;
          clk_next  = CLK_SUB;
          load      = 1'b1;
          exc_go    = 1'b1;
        end else if (wake_watch) begin
          mode_next = M_SETTLE;
          tgt_next  = act_clk;
          load      = 1'b1;
          load_val  = settle_cnt;
        end
      end
      M_SSLEEP: begin
        if (wake_any) begin
          mode_next = M_EXC;
          clk_next  = CLK_SUB;
          load      = 1'b1;
          exc_go    = 1'b1;
        end
      end
      M_DTOLD: begin
        if (done && via_reg && (tgt_clk_reg != CLK_SUB)) begin
          mode_next = M_SETTLE;
          load      = 1'b1;
          load_val  = settle_cnt;
        end else if (done) begin
          mode_next = M_EXC;
          clk_next  = tgt_clk_reg;
          load      = 1'b1;
          exc_go    = 1'b1;
        end
      end
      M_SETTLE: begin
        if (done) begin
          mode_next = M_EXC;
          clk_next  = tgt_clk_reg;
          load      = 1'b1;
          exc_go    = 1'b1;
        end
      end
      M_EXC: begin
        if (done) begin
          dt_next = 1'b0;
          if (run_clk_reg == CLK_SUB) begin
            mode_next = M_SUB;
          end else if (run_clk_reg == CLK_MS) begin
            mode_next = M_MS;
          end else begin
            mode_next = M_HS;
          end
        end
      end
      default: begin
        mode_next = M_RESET;
        clk_next  = CLK_HS;
      end
    endcase
  end

  // Mode register; the reset pin overrides every other bit
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_reg    <= M_RESET;
      run_clk_reg <= CLK_HS;
      tgt_clk_reg <= CLK_HS;
      via_reg     <= 1'b0;
      dt_reg      <= 1'b0;
    end else if (!i_reset_pin_n) begin
      mode_reg    <= M_RESET;
      run_clk_reg <= CLK_HS;
      tgt_clk_reg <= CLK_HS;
      via_reg     <= 1'b0;
      dt_reg      <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      run_clk_reg <= clk_next;
      tgt_clk_reg <= tgt_next;
      via_reg     <= via_next;
      dt_reg      <= dt_next;
    end
  end

  // State counter, paced by the clock of the current phase
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 18'h00000;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (tick && (cnt_reg != 18'h00000)) begin
      cnt_reg <= cnt_reg - 18'h00001;
    end
  end

  // CPU runs while executing, in the direct-transfer old-clock states, or handling the exception
  assign cpu_run = act_s || (mode_reg == M_DTOLD) || (mode_reg == M_EXC);

  // Registered outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cpu_ce      <= 1'b0;
      o_cpu_reset   <= 1'b1;
      o_main_osc_on <= 1'b1;
      o_exc_start   <= 1'b0;
      o_dt_int      <= 1'b0;
    end else begin
      o_cpu_ce      <= tick && cpu_run && i_reset_pin_n;
      o_cpu_reset   <= !i_reset_pin_n || (mode_reg == M_RESET && mode_next == M_RESET);
      o_main_osc_on <= !((mode_next == M_STBY) || (mode_next == M_WATCH) ||
                         (mode_next == M_SUB) || (mode_next == M_SSLEEP));
      o_exc_start   <= exc_go && i_reset_pin_n;
      o_dt_int      <= exc_go && dt_reg && i_reset_pin_n;
    end
  end

  assign o_mode    = mode_reg;
  assign o_run_clk = run_clk_reg;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  pin_reset_a: assert property (!i_reset_pin_n |=> mode_reg == M_RESET && o_cpu_reset)
    else $error("reset pin did not force reset");
  stby_entry_a: assert property ((act_s && i_sleep_exec && i_reset_pin_n && run_clk_reg != CLK_SUB &&
    i_software_standby_select && !i_low_speed_select && !i_timer_a_watch_select) |=> mode_reg == M_STBY)
    else $error("standby not entered");
  watch_entry_a: assert property ((act_s && i_sleep_exec && i_reset_pin_n && i_software_standby_select &&
    i_timer_a_watch_select && !i_direct_transfer_on) |=> mode_reg == M_WATCH)
    else $error("watch not entered");
  sleep_entry_a: assert property ((act_s && i_sleep_exec && i_reset_pin_n && run_clk_reg != CLK_SUB &&
    !i_software_standby_select && !i_low_speed_select && !i_direct_transfer_on) |=> mode_reg == M_SLEEP)
    else $error("sleep not entered");
  mask_hold_a: assert property (((mode_reg == M_SLEEP) || (mode_reg == M_STBY) || (mode_reg == M_WATCH) ||
    (mode_reg == M_SSLEEP)) && i_cond_code_int_mask && i_reset_pin_n |=> mode_reg == $past(mode_reg))
    else $error("masked interrupt left low-power mode");
  dt_dis_a: assert property ((act_s && i_sleep_exec && i_direct_transfer_on && !i_dt_int_en)
    |=> mode_reg != M_DTOLD)
    else $error("disabled direct transfer went ahead");
  dt_mask_a: assert property ((act_s && i_sleep_exec && i_direct_transfer_on && i_cond_code_int_mask)
    |=> mode_reg != M_DTOLD && !o_dt_int)
    else $error("masked direct transfer went ahead");
  hs_to_ms_a: assert property ((mode_reg == M_HS && i_sleep_exec && i_reset_pin_n && dt_ok &&
    !i_software_standby_select && !i_low_speed_select && i_medium_speed_select)
    |=> mode_reg == M_DTOLD && tgt_clk_reg == CLK_MS)
    else $error("high to medium transfer not started");
  dt_lat_a: assert property ((act_s && i_sleep_exec && slp_mode == M_DTOLD && !slp_via && i_reset_pin_n)
    |-> ##[4:80] o_dt_int)
    else $error("direct transfer interrupt late");
  exc_len_a: assert property ((o_exc_start && i_reset_pin_n) |-> mode_reg == M_EXC && cnt_reg == EXC_CNT)
    else $error("exception phase not loaded with its state count");

  dt_hs_ms_c: cover property (mode_reg == M_DTOLD && tgt_clk_reg == CLK_MS ##[1:80] o_dt_int);
  settle_c: cover property (mode_reg == M_SETTLE ##1 mode_reg == M_EXC);
  ms_wake_c: cover property (mode_reg == M_EXC && run_clk_reg == CLK_MS && !dt_reg);

endmodule

// ==== hw/pmdt_pkg.sv ====
// Constants, codes and state types of the power-mode and direct-transfer controller
package pmdt_pkg;

  // CPU clock rates in oscillator cycles per CPU state
  localparam int         HS_DIV      = 2;
  localparam int         MS_RATIO    = 8;
  localparam logic [3:0] HS_LIM      = 4'(HS_DIV - 1);
  localparam logic [3:0] MS_LIM      = 4'(HS_DIV * MS_RATIO - 1);

  // Subactive divider, counted in watch clock ticks
  localparam logic [1:0] SUB_SEL_D8  = 2'h0;
  localparam logic [1:0] SUB_SEL_D4  = 2'h1;
  localparam logic [3:0] SUB_LIM_D8  = 4'h7;
  localparam logic [3:0] SUB_LIM_D4  = 4'h3;
  localparam logic [3:0] SUB_LIM_D2  = 4'h1;

  // Direct-transfer state counts
  localparam int          SLEEP_STATES = 2;
  localparam int          PROC_STATES  = 1;
  localparam int          EXC_STATES   = 14;
  localparam logic [17:0] DT_OLD_CNT   = 18'(SLEEP_STATES + PROC_STATES);
  localparam logic [17:0] EXC_CNT      = 18'(EXC_STATES);

  // Settling wait select: codes 1xx give the longest wait
  localparam logic [2:0]  STS_MAX_SHIFT = 3'h4;

  // Clock that paces CPU states
  typedef enum logic [2:0] {
    CLK_HS  = 3'b001,
    CLK_MS  = 3'b010,
    CLK_SUB = 3'b100
  } pmdt_clk_e;

  // Operating modes and transition phases
  typedef enum logic [10:0] {
    M_RESET  = 11'b000_0000_0001,
    M_HS     = 11'b000_0000_0010,
    M_MS     = 11'b000_0000_0100,
    M_SUB    = 11'b000_0000_1000,
    M_SLEEP  = 11'b000_0001_0000,
    M_STBY   = 11'b000_0010_0000,
    M_WATCH  = 11'b000_0100_0000,
    M_SSLEEP = 11'b000_1000_0000,
    M_DTOLD  = 11'b001_0000_0000,
    M_SETTLE = 11'b010_0000_0000,
    M_EXC    = 11'b100_0000_0000
  } pmdt_mode_e;

endpackage

// ==== test/pmdt_cpu_model.sv ====
// CPU-side model: SLEEP execution and free-running watch clock ticks
`timescale 1ns/1ns
module pmdt_cpu_model #(
  parameter int WATCH_PER = 4  // System cycles per watch clock cycle
) (
  // Clock
  input  wire logic i_sys_clk,
  // Toward the controller
  output logic      o_sleep_exec,
  output logic      o_watch_tick
);
  int wcnt;

  // Watch clock runs free, one-cycle tick per period, driven off the sampling edge
  initial begin
    o_sleep_exec = 1'b0;
    o_watch_tick = 1'b0;
    wcnt = 0;
    forever begin
      @(negedge i_sys_clk);
      wcnt = (wcnt + 1) % WATCH_PER;
      o_watch_tick = (wcnt == 0);
    end
  end

  // SLEEP held for exactly one cycle so it is taken once
  task automatic sleep();
    @(negedge i_sys_clk);
    o_sleep_exec = 1'b1;
    @(negedge i_sys_clk);
    o_sleep_exec = 1'b0;
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the power-mode and direct-transfer controller
`timescale 1ns/1ns
module testbench;
  import pmdt_pkg::*;
  // Design inputs: sel is {standby, low, medium, direct, timer bit}
  logic        clk   = 1'b0;
  logic        rst_b = 1'b0;
  logic        pin_n = 1'b1;
  logic        mask  = 1'b0;
  logic        dt_en = 1'b1;
  logic [4:0]  sel   = 5'h00;
  logic [2:0]  sts   = 3'h0;
  logic [1:0]  sa    = 2'h0;
  logic [11:0] req   = 12'h000;
  logic [11:0] en    = 12'hFFF;
  wire         slp;
  wire         wtick;
  // Design outputs and bookkeeping
  pmdt_mode_e  mode;
  pmdt_clk_e   run_clk;
  logic        cpu_ce, cpu_reset, osc_on, exc, dt_int;
  int          errors = 0;
  int          n_compared = 0;
  int          sb[4] = '{0, 1, 4, 11};
  int          wt[4] = '{2, 0, 4, 11};

  // Clock at 125 MHz
  initial begin
    forever #4 clk = ~clk;
  end

  pmdt_cpu_model #(.WATCH_PER(4)) cpu (.i_sys_clk(clk), .o_sleep_exec(slp), .o_watch_tick(wtick));

  pmdt_ctrl #(.SETTLE_BASE(4)) DUT (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_reset_pin_n(pin_n), .i_watch_tick(wtick),
    .i_sleep_exec(slp), .i_cond_code_int_mask(mask), .i_software_standby_select(sel[4]),
    .i_low_speed_select(sel[3]), .i_medium_speed_select(sel[2]), .i_direct_transfer_on(sel[1]),
    .i_timer_a_watch_select(sel[0]), .i_settle_wait_sel(sts), .i_sub_div_sel(sa),
    .i_ext_int_zero(req[0]), .i_ext_int_one(req[1]), .i_wake_pin(req[11:4]), .i_timer_a_int(req[2]),
    .i_other_int(req[3]), .i_ext_int_zero_en(en[0]), .i_ext_int_one_en(en[1]), .i_wake_pin_en(en[11:4]),
    .i_timer_a_int_en(en[2]), .i_other_int_en(en[3]), .i_dt_int_en(dt_en), .o_mode(mode),
    .o_run_clk(run_clk), .o_cpu_ce(cpu_ce), .o_cpu_reset(cpu_reset), .o_main_osc_on(osc_on),
    .o_exc_start(exc), .o_dt_int(dt_int)
  );

  // Comparison helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_in(input string what, input int n, input int lo, input int hi);
    n_compared++;
    if (n < lo || n > hi) begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
  endtask

  // Waits bounded by a cycle limit
  task automatic wait_for(input pmdt_mode_e m, input int lim, output int n);
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_exc(input int lim, output int n);
    n = 0;
    while (exc !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Cycles between two CPU state strobes
  task automatic ce_gap(output int n);
    n = 0;
    while (cpu_ce !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_ce !== 1'b1 && n < 300);
  endtask

  // Reset pin pulse and recovery to high-speed
  task automatic pin_reset();
    int n;
    pin_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset mode", 16'(mode), 16'(M_RESET));
    chk("cpu reset", 16'(cpu_reset), 16'h0001);
    pin_n = 1'b1;
    wait_for(M_HS, 4, n);
    repeat (2) @(negedge clk);
    chk("run mode", 16'(mode), 16'(M_HS));
    chk("cpu run", 16'(cpu_reset), 16'h0000);
    mask = 1'b0;
    dt_en = 1'b1;
    $display("test pin_reset done");
  endtask

  // Direct transfer: old-clock states, settle states, exception states
  task automatic dt(input logic [4:0] v, input pmdt_clk_e nclk, input int ok, input int nk, input int st,
                    input pmdt_mode_e tgt);
    int n;
    @(negedge clk);
    sel = v;
    cpu.sleep();
    sel = 5'h00;
    wait_exc(4 * ok + st * nk + nk + 20, n);
    chk_in("dt delay", n, 2 * ok - 2 + st * nk, 4 * ok + st * nk + nk + 2);
    chk("dt int", 16'(dt_int), 16'h0001);
    chk("new clk", 16'(run_clk), 16'(nclk));
    wait_for(tgt, 16 * nk + 4, n);
    chk_in("exc states", n, 13 * nk, 15 * nk + 2);
    chk("dt mode", 16'(mode), 16'(tgt));
    $display("test dt done");
  endtask

  // Low-power entry, refused wakes, then a qualified wake to medium-speed
  task automatic lowpow(input logic [4:0] v, input pmdt_mode_e lp, input int i);
    int n;
    @(negedge clk);
    sel = v;
    cpu.sleep();
    wait_for(lp, 4, n);
    chk("enter", 16'(mode), 16'(lp));
    chk("osc", 16'(osc_on), 16'(lp == M_SLEEP));
    en[i] = 1'b0;
    req[i] = 1'b1;
    repeat (4) @(negedge clk);
    chk("disabled", 16'(mode), 16'(lp));
    en[i] = 1'b1;
    mask = 1'b1;
    repeat (4) @(negedge clk);
    chk("masked", 16'(mode), 16'(lp));
    mask = 1'b0;
    wait_exc(3000, n);
    chk("wake exc", 16'(exc), 16'h0001);
    chk("no dt", 16'(dt_int), 16'h0000);
    wait_for(M_MS, 300, n);
    chk("wake mode", 16'(mode), 16'(M_MS));
    req[i] = 1'b0;
    $display("test lowpow done");
  endtask

  // Direct transfer refused by disabled interrupt or mask
  task automatic refused(input logic [4:0] v, input pmdt_mode_e lp, input logic m);
    int n;
    dt_en = m;
    mask = m;
    @(negedge clk);
    sel = v;
    cpu.sleep();
    wait_for(lp, 4, n);
    chk("refused", 16'(mode), 16'(lp));
    if (m) begin
      req[0] = 1'b1;
      repeat (8) @(negedge clk);
      chk("stuck", 16'(mode), 16'(lp));
      req[0] = 1'b0;
    end
    pin_reset();
  endtask

  // Subsleep or watch from subactive, masked wake refused, then wake back to subactive
  task automatic subwake(input logic [4:0] v, input pmdt_mode_e lp);
    int n;
    @(negedge clk);
    sel = v;
    cpu.sleep();
    wait_for(lp, 4, n);
    chk("sub enter", 16'(mode), 16'(lp));
    chk("sub osc", 16'(osc_on), 16'h0000);
    mask = 1'b1;
    req[0] = 1'b1;
    repeat (8) @(negedge clk);
    chk("sub masked", 16'(mode), 16'(lp));
    mask = 1'b0;
    wait_exc(8, n);
    chk("sub exc", 16'(exc), 16'h0001);
    chk("sub clk", 16'(run_clk), 16'(CLK_SUB));
    wait_for(M_SUB, 16 * 32 + 4, n);
    chk("sub back", 16'(mode), 16'(M_SUB));
    req[0] = 1'b0;
    $display("test subwake done");
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog sized well beyond the longest expected run
  initial begin
    #400000;
    errors++;
    $display("BAD watchdog expected finish seen hang");
    test_done();
  end

  // Main sequence
  initial begin
    int n;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    wait_for(M_HS, 4, n);
    pin_reset();
    dt(5'b00110, CLK_MS, 2, 16, 0, M_MS);
    ce_gap(n);
    chk_in("ms state", n, 16, 16);
    dt(5'b00010, CLK_HS, 16, 2, 0, M_HS);
    ce_gap(n);
    chk_in("hs state", n, 2, 2);
    lowpow(5'b00100, M_SLEEP, 3);
    foreach (sb[k]) lowpow(5'b10100, M_STBY, sb[k]);
    foreach (wt[k]) lowpow(5'b10101, M_WATCH, wt[k]);
    refused(5'b00010, M_SLEEP, 1'b0);
    refused(5'b11011, M_WATCH, 1'b0);
    refused(5'b00110, M_SLEEP, 1'b1);
    refused(5'b11011, M_WATCH, 1'b1);
    dt(5'b11011, CLK_SUB, 2, 32, 0, M_SUB);
    chk("osc off", 16'(osc_on), 16'h0000);
    for (int c = 0; c < 3; c++) begin
      sa = 2'(c);
      ce_gap(n);
      chk_in("sub state", n, 32 >> c, 32 >> c);
    end
    sa = 2'h0;
    subwake(5'b01001, M_SSLEEP);
    sts = 3'h1;
    dt(5'b10011, CLK_HS, 32, 2, 8, M_HS);
    dt(5'b11011, CLK_SUB, 2, 32, 0, M_SUB);
    subwake(5'b11001, M_WATCH);
    sts = 3'h4;
    dt(5'b10111, CLK_MS, 32, 16, 64, M_MS);
    test_done();
  end
endmodule
